// ===== dpc_pkg.sv
/*
  Package for the dual-port coordination host controller: command codes,
  pin bundles, address constants and pin timing counts.
  Assumes a 200 MHz system clock and one port of the dual-port memory.
*/
package dpc_pkg;
  // ==========================================================================
  // address and data layout
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FLAG_IDX_W = 3;
  localparam logic [15:0] MAIL_LEFT_ADDR = 16'hFFFE;
  localparam logic [15:0] MAIL_RIGHT_ADDR = 16'hFFFF;
  localparam logic [7:0] FLAG_FREE = 8'hFF;
  localparam logic [7:0] FLAG_HELD = 8'h00;

  // ==========================================================================
  // software register map (word indices)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_PINS = 4'h5;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ctrl field: bit0..1 command, bit2 start
  localparam int CTRL_START_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_COLL_BIT = 1;
  localparam int STAT_GRANT_BIT = 2;

  // ==========================================================================
  // timing: pin step time and derived cycle count
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STEP_TIME_PS = 25000;
  localparam int STEP_CYCLES = (STEP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] STEP_CNT = 4'(STEP_CYCLES);
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    CMD_MEM_READ,
    CMD_MEM_WRITE,
    CMD_FLAG_READ,
    CMD_FLAG_WRITE
  } dpc_cmd_t;

  typedef struct packed {
    logic portEnable_n;
    logic flag_space_select_n;
    logic readDrive_n;
    logic writeStrobe_n;
    logic [ADDR_W-1:0] addr;
  } dpc_ctl_t;
endpackage

// ===== dpc_host.sv
/*
  Host controller for one port of the dual-port coordination logic.
  Software orders single memory or semaphore cycles through a small register
  port; the controller drives the port pins for fixed step counts, samples the collision flag,
  and reports read data and mailbox/collision state.
  Assumes the device sits on asynchronous pins sampled on clk_sys.
*/
// Design decisions made here: the plain strobed port and the placing of the registers.
//
// Contract
// - flag access: enable high, select low
// - slave collision pin tied high normally
// - hold address until collision settles
// - one master per address range
`timescale 1ns/1ps
module dpc_host #(
  // a step of at least 2 lets the synchronised pins settle before capture
  parameter int STEP = dpc_pkg::STEP_CYCLES
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output dpc_pkg::dpc_ctl_t pinCtl,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic [7:0] dataIn,
  input wire logic collision_flag_n,
  input wire logic mail_irq_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} dpc_state_t;

  dpc_state_t state_q;
  logic [1:0] cmd_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q, rdata_q;
  logic [3:0] cnt_q;
  logic coll_q, grant_q;
  logic [2:0] collSync_q, irqSync_q;
  logic [7:0] dinS1_q, dinS2_q, dinS3_q, dinStable_q;
  logic collLow, irqLow;

  // ==========================================================================
  // pin synchronisers: change counts once second and third stages agree
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      // collision comes from the single master and idles high
      collSync_q <= 3'h7;
      irqSync_q <= 3'h7;
      dinS1_q <= 8'h00;
      dinS2_q <= 8'h00;
      dinS3_q <= 8'h00;
    end
    else
    begin
      collSync_q <= {collSync_q[1:0], collision_flag_n};
      irqSync_q <= {irqSync_q[1:0], mail_irq_n};
      dinS1_q <= dataIn;
      dinS2_q <= dinS1_q;
      dinS3_q <= dinS2_q;
    end

  logic collLow_q, irqLow_q;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      collLow_q <= 1'b0;
      irqLow_q <= 1'b0;
      dinStable_q <= 8'h00;
    end
    else
    begin
      if (collSync_q[1] == collSync_q[2]) collLow_q <= !collSync_q[2];
      if (irqSync_q[1] == irqSync_q[2]) irqLow_q <= !irqSync_q[2];
      if (dinS2_q == dinS3_q) dinStable_q <= dinS3_q;
    end
  assign collLow = collLow_q;
  assign irqLow = irqLow_q;

  function automatic logic isFlag(input logic [1:0] c);
    isFlag = (c == 2'(dpc_pkg::CMD_FLAG_READ)) || (c == 2'(dpc_pkg::CMD_FLAG_WRITE));
  endfunction
  function automatic logic isWrite(input logic [1:0] c);
    isWrite = (c == 2'(dpc_pkg::CMD_MEM_WRITE)) || (c == 2'(dpc_pkg::CMD_FLAG_WRITE));
  endfunction

  wire startCmd = regWr && (regAddr == dpc_pkg::REG_CTRL)
    && regWdata[dpc_pkg::CTRL_START_BIT] && (state_q == ST_IDLE);

  // ==========================================================================
  // software register writes
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      cmd_q <= 2'h0;
    end
    else if (regWr)
    begin
      if (regAddr == dpc_pkg::REG_ADDR) addr_q <= regWdata[15:0];
      else if (regAddr == dpc_pkg::REG_WDATA) wdata_q <= regWdata[7:0];
      else if (startCmd) cmd_q <= regWdata[1:0];
    end

  // ==========================================================================
  // pin cycle sequencer
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= dpc_pkg::CNT_ZERO;
    end
    else
      case (state_q)
        ST_IDLE:
          if (startCmd)
          begin
            state_q <= ST_SETUP;
            cnt_q <= 4'(STEP);
          end
        ST_SETUP:
          // address and enable settle before the strobe
          if (cnt_q != dpc_pkg::CNT_ZERO) cnt_q <= cnt_q - 4'h1;
          else
          begin
            state_q <= ST_STROBE;
            cnt_q <= 4'(STEP);
          end
        ST_STROBE:
          if (cnt_q != dpc_pkg::CNT_ZERO) cnt_q <= cnt_q - 4'h1;
          else
          begin
            state_q <= ST_RECOVER;
            cnt_q <= 4'(STEP);
          end
        default:
          if (cnt_q != dpc_pkg::CNT_ZERO) cnt_q <= cnt_q - 4'h1;
          else state_q <= ST_IDLE;
      endcase

  // ==========================================================================
  // pin drive
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      pinCtl <= '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
      dataOut <= 8'h00;
      dataOe <= 1'b0;
    end
    else
    begin
      if (state_q == ST_IDLE && startCmd)
      begin
        // flag space: memory enable high, select low, three index bits
        pinCtl.portEnable_n <= isFlag(regWdata[1:0]);
        pinCtl.flag_space_select_n <= !isFlag(regWdata[1:0]);
        pinCtl.addr <= isFlag(regWdata[1:0]) ? {13'h0000, addr_q[2:0]} : addr_q;
        pinCtl.readDrive_n <= isWrite(regWdata[1:0]);
        // request or release uses bit zero only
        dataOut <= isFlag(regWdata[1:0]) ? {7'h00, wdata_q[0]} : wdata_q;
        dataOe <= isWrite(regWdata[1:0]);
      end
      else if (state_q == ST_SETUP && cnt_q == dpc_pkg::CNT_ZERO)
        pinCtl.writeStrobe_n <= !isWrite(cmd_q);
      else if (state_q == ST_STROBE && cnt_q == dpc_pkg::CNT_ZERO)
      begin
        pinCtl.writeStrobe_n <= 1'b1;
        // deselect so the latched flag value is refreshed next read
        pinCtl.readDrive_n <= 1'b1;
        pinCtl.portEnable_n <= 1'b1;
        pinCtl.flag_space_select_n <= 1'b1;
      end
      else if (state_q == ST_RECOVER && cnt_q == dpc_pkg::CNT_ZERO)
        dataOe <= 1'b0;
    end

  // ==========================================================================
  // result capture
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      rdata_q <= 8'h00;
      coll_q <= 1'b0;
      grant_q <= 1'b0;
    end
    else if (startCmd)
      coll_q <= 1'b0;
    else if (state_q == ST_STROBE && cnt_q == dpc_pkg::CNT_ZERO)
    begin
      rdata_q <= dinStable_q;
      // a collided memory read or write is reported; the device blocks a collided write
      coll_q <= collLow && !isFlag(cmd_q);
      // all zeros means this side owns the flag
      if (isFlag(cmd_q) && !isWrite(cmd_q)) grant_q <= (dinStable_q == dpc_pkg::FLAG_HELD);
    end

  // ==========================================================================
  // software reads, data one cycle later
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) regRdata <= dpc_pkg::READ_ZERO;
    else if (!regRd) regRdata <= dpc_pkg::READ_ZERO;
    else if (regAddr == dpc_pkg::REG_ADDR) regRdata <= {16'h0000, addr_q};
    else if (regAddr == dpc_pkg::REG_WDATA) regRdata <= {24'h000000, wdata_q};
    else if (regAddr == dpc_pkg::REG_STATUS)
      regRdata <= {28'h0000000, irqLow, grant_q, coll_q, state_q != ST_IDLE};
    else if (regAddr == dpc_pkg::REG_RDATA) regRdata <= {24'h000000, rdata_q};
    else if (regAddr == dpc_pkg::REG_PINS) regRdata <= {30'h00000000, irqLow, collLow};
    else regRdata <= dpc_pkg::READ_ZERO;

  // ==========================================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence setupDone;
    state_q == ST_SETUP && cnt_q == dpc_pkg::CNT_ZERO;
  endsequence

  flag_select_a: assert property (!pinCtl.flag_space_select_n |-> pinCtl.portEnable_n)
    else $error("flag access with memory enable low");
  strobe_order_a: assert property (setupDone |=> pinCtl.writeStrobe_n == !isWrite(cmd_q))
    else $error("write strobe not started after setup");
  strobe_late_a: assert property ($fell(pinCtl.writeStrobe_n) |-> $past(state_q) == ST_SETUP)
    else $error("write strobe began before setup ended");
  flag_bit_a: assert property (!pinCtl.flag_space_select_n |-> dataOut[7:1] == 7'h00)
    else $error("flag write used upper data bits");
  flag_index_a: assert property (!pinCtl.flag_space_select_n |-> pinCtl.addr[15:3] == 13'h0000)
    else $error("flag address beyond three index bits");
  deselect_a: assert property (state_q == ST_RECOVER |-> pinCtl.readDrive_n)
    else $error("read drive left active between accesses");
endmodule

// ===== dpc_dev_model.sv
/*
  Behavioural model of the dual-port device as seen from the host's left port.
  Assumes the bench plays the right port by calling the tasks of this model.
*/
`timescale 1ns/1ps
module dpc_dev_model (
  input wire dpc_pkg::dpc_ctl_t c,
  input wire logic [7:0] d,
  output logic [7:0] q,
  output logic collN,
  output logic irqN
);
  // ==========================================================================
  // state
  logic [7:0] mem [logic [15:0]];
  bit [1:0] own [8];
  bit [1:0] req [8];
  bit live;
  bit rHold;
  logic [15:0] rAddr;
  logic rIrqN = 1'b1;
  initial irqN = 1'b1;
  initial q = 8'h5A;
  // right side holds rAddr first, so the later left access is flagged
  assign collN = !(rHold && !c.portEnable_n && c.addr == rAddr);
  // ==========================================================================
  // semaphores: one request latch per side, one owner code (0 free, 1 left, 2 right)
  task automatic semWr(input int s, input int i, input bit b);
    if (!b)
    begin
      req[i][s] = 1'b1;
      if (own[i] == 2'd0) own[i] = 2'(s + 1);
    end
    else
    begin
      req[i][s] = 1'b0;
      if (own[i] == 2'(s + 1)) own[i] = req[i][1 - s] ? 2'(2 - s) : 2'd0;
    end
  endtask
  function automatic logic [7:0] flagVal(input int s, input int i);
    return (own[i] == 2'(s + 1)) ? dpc_pkg::FLAG_HELD : dpc_pkg::FLAG_FREE;
  endfunction
  task automatic rWrite(input logic [15:0] a, input logic [7:0] v);
    mem[a] = v;
    if (a == dpc_pkg::MAIL_LEFT_ADDR) irqN = 1'b0;
  endtask
  task automatic rRead(input logic [15:0] a, output logic [7:0] v);
    v = mem[a];
    if (a == dpc_pkg::MAIL_RIGHT_ADDR) rIrqN = 1'b1;
  endtask
  // ==========================================================================
  // left port
  always @(negedge c.readDrive_n or negedge c.flag_space_select_n)
    if (live && !c.readDrive_n && !c.flag_space_select_n && c.portEnable_n)
      q = flagVal(0, int'(c.addr[2:0]));
  always @(negedge c.readDrive_n)
    if (live && !c.portEnable_n)
    begin
      q = mem[c.addr];
      if (c.addr == dpc_pkg::MAIL_LEFT_ADDR) irqN = 1'b1;
    end
  // a released bus shows the inverse of its last value
  always @(posedge c.readDrive_n) q = ~q;
  always @(negedge c.writeStrobe_n)
    if (live && !c.portEnable_n && collN)
    begin
      mem[c.addr] = d;
      if (c.addr == dpc_pkg::MAIL_RIGHT_ADDR) rIrqN = 1'b0;
    end
    else if (live && c.portEnable_n && !c.flag_space_select_n)
      semWr(0, int'(c.addr[2:0]), d[0]);
endmodule

// ===== dpc_host_tb_top.sv
/*
  Self-checking bench for the host controller against the device model.
  Assumes the host sits on the left port and the bench plays the right port.
*/
`timescale 1ns/1ps
module dpc_host_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  dpc_pkg::dpc_ctl_t pinCtl;
  logic [7:0] dataOut;
  logic [7:0] dataIn;
  logic dataOe;
  logic collN;
  logic irqN;
  logic [31:0] v;
  logic [7:0] b;
  int errors = 0;
  int total_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  dpc_host #(.STEP(dpc_pkg::STEP_CYCLES)) dut (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinCtl(pinCtl),
    .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .collision_flag_n(collN),
    .mail_irq_n(irqN));
  dpc_dev_model dev (.c(pinCtl), .d(dataOut), .q(dataIn), .collN(collN), .irqN(irqN));
  // ==========================================================================
  // helpers
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task cmd(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d);
    int n;
    wr(dpc_pkg::REG_ADDR, {16'h0000, a});
    wr(dpc_pkg::REG_WDATA, {24'h000000, d});
    wr(dpc_pkg::REG_CTRL, {29'h0, 1'b1, c});
    for (n = 0; n < 100; n++)
    begin
      rd(dpc_pkg::REG_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    if (n == 100)
    begin
      errors++;
      end_sim();
    end
  endtask
  task flagRd(input logic [15:0] a, input logic [7:0] e);
    cmd(2'h2, a, 8'h00);
    rd(dpc_pkg::REG_RDATA, v);
    chk("left flag", v[7:0], e);
    rd(dpc_pkg::REG_STATUS, v);
    chk("grant", {7'h00, v[2]}, {7'h00, e == dpc_pkg::FLAG_HELD});
  endtask
  // ==========================================================================
  // scenarios
  task t_sem;
    cmd(2'h3, 16'h0005, 8'hFE);
    flagRd(16'h0005, 8'h00);
    chk("right flag", dev.flagVal(1, 5), 8'hFF);
    dev.semWr(1, 5, 1'b0);
    flagRd(16'h0005, 8'h00);
    chk("right flag", dev.flagVal(1, 5), 8'hFF);
    flagRd(16'h0002, 8'hFF);
    cmd(2'h3, 16'h0005, 8'h01);
    flagRd(16'h0005, 8'hFF);
    chk("right flag", dev.flagVal(1, 5), 8'h00);
    cmd(2'h3, 16'h0005, 8'h00);
    dev.semWr(1, 5, 1'b1);
    flagRd(16'h0005, 8'h00);
    cmd(2'h3, 16'h0005, 8'h01);
    flagRd(16'h0005, 8'hFF);
    chk("right flag", dev.flagVal(1, 5), 8'hFF);
    $display("test semaphore done");
  endtask
  task t_mail;
    dev.rWrite(16'hFFFE, 8'hA5);
    @(posedge clk_sys);
    chk("left irq", {7'h00, irqN}, 8'h00);
    repeat (3) @(posedge clk_sys);
    rd(dpc_pkg::REG_STATUS, v);
    chk("irq status", {7'h00, v[3]}, 8'h01);
    cmd(2'h0, 16'hFFFE, 8'h00);
    rd(dpc_pkg::REG_RDATA, v);
    chk("left mail", v[7:0], 8'hA5);
    chk("left irq", {7'h00, irqN}, 8'h01);
    rd(dpc_pkg::REG_PINS, v);
    chk("irq pin", {7'h00, v[1]}, 8'h00);
    cmd(2'h1, 16'hFFFF, 8'h3C);
    chk("right irq", {7'h00, dev.rIrqN}, 8'h00);
    dev.rRead(16'hFFFF, b);
    chk("right mail", b, 8'h3C);
    chk("right irq", {7'h00, dev.rIrqN}, 8'h01);
    rd(4'hF, v);
    chk("unmapped", v[7:0], 8'h00);
    $display("test mailbox done");
  endtask
  task t_coll;
    dev.rWrite(16'h0100, 8'h11);
    dev.rAddr = 16'h0100;
    dev.rHold = 1'b1;
    cmd(2'h1, 16'h0100, 8'h22);
    rd(dpc_pkg::REG_STATUS, v);
    chk("collision", {7'h00, v[1]}, 8'h01);
    dev.rRead(16'h0100, b);
    chk("blocked write", b, 8'h11);
    cmd(2'h0, 16'h0100, 8'h00);
    rd(dpc_pkg::REG_STATUS, v);
    chk("read collision", {7'h00, v[1]}, 8'h01);
    dev.rHold = 1'b0;
    cmd(2'h1, 16'h0100, 8'h22);
    dev.rRead(16'h0100, b);
    chk("free write", b, 8'h22);
    $display("test collision done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    dev.live = 1'b1;
    t_sem();
    t_mail();
    t_coll();
    end_sim();
  end
  initial
  begin
    #200000;
    errors++;
    end_sim();
  end
endmodule
